// *** bench/cfg_host.sv ***
// Behavioural configuration host that shifts bytes onto the serial pins
`default_nettype none
module cfg_host (
  // Clock lines and data
  output var logic bit_clk,
  output var logic usr_clk,
  output var logic data,
  // Select the user clock line
  input  wire logic sel_usr
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clocks idle low between frames
  initial begin
    bit_clk = 1'b0;
    usr_clk = 1'b0;
    data = 1'b0;
  end
  // One 40 ns pulse on the chosen clock line
  task pulse();
    if (sel_usr) usr_clk = 1'b1;
    else bit_clk = 1'b1;
    #40;
    usr_clk = 1'b0;
    bit_clk = 1'b0;
    #20;
  endtask : pulse
  // Send one byte, low bit first; released data shows the inverse
  task send(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      data = b[i];
      #20;
      pulse();
    end
    data = ~data;
  endtask : send
  // Extra falling edges after load completes
  task falls(input int n);
    repeat (n) pulse();
  endtask : falls
endmodule : cfg_host
`default_nettype wire

// *** bench/tb_top.sv ***
// Bench for the passive serial configuration port
`default_nettype none
module tb_top;
  import ps_config_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [23:0] BITS = 24'h000010;
  logic       sys_clk;
  logic       nrst;
  logic       req_n;
  logic       en_n;
  logic       use_usr;
  logic       bclk, uclk, sdata, en_out_n, st_out, st_oe, ld_out, ld_oe, vld, umode;
  logic [7:0] cbyte;
  logic [7:0] got[$];
  int         err_total = 0;
  int         n_compared = 0;
  // Open-drain lines with pull-ups: the driven level while enabled, high otherwise
  wire        st_line;
  wire        ld_line;
  assign st_line = st_oe ? st_out : 1'b1;
  assign ld_line = ld_oe ? ld_out : 1'b1;
  always #5 sys_clk = ~sys_clk;
  cfg_host host (.bit_clk(bclk), .usr_clk(uclk), .data(sdata), .sel_usr(use_usr));
  passive_serial_config_port #(.IMAGE_BITS(BITS)) DUT (
    .sys_clk(sys_clk), .nrst(nrst), .reconfig_request_n(req_n),
    .config_enable_in_n(en_n), .config_bit_clock(bclk), .user_supplied_clock(uclk),
    .use_user_clock(use_usr), .serial_data_in(sdata), .config_enable_out_n(en_out_n),
    .config_error_status_n_in(st_line), .config_error_status_n_out(st_out),
    .config_error_status_n_oe(st_oe), .load_complete_in(ld_line),
    .load_complete_out(ld_out), .load_complete_oe(ld_oe), .config_byte(cbyte),
    .config_byte_valid(vld), .user_mode(umode));
  // Collect every delivered byte
  always @(negedge sys_clk) if (vld === 1'b1) got.push_back(cbyte);
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task pulse_request();
    cyc(1);
    req_n = 1'b0;
    cyc(6);
    check(umode === 1'b0 && st_line === 1'b0 && ld_line === 1'b0, "not reset");
    cyc(20);
    check(st_oe === 1'b1 && en_out_n === 1'b1, "left reset early");
    req_n = 1'b1;
    cyc(6);
  endtask : pulse_request
  // Good image, handoff and start-up
  task test_load();
    got.delete();
    host.send(SYNC_BYTE_DEFAULT);
    cyc(5);
    check(ld_oe === 1'b1 && en_out_n === 1'b1, "released early");
    host.send(8'hA5);
    cyc(5);
    // The last data bit's falling edge is the first edge after release
    check(ld_oe === 1'b0 && en_out_n === 1'b0 && umode === 1'b0, "handoff");
    host.falls(1);
    cyc(5);
    check(umode === 1'b1, "no user mode after second fall");
    host.falls(1);
    cyc(5);
    check(umode === 1'b1 && ld_line === 1'b1, "user mode lost");
    check(got.size() == 2 && got[0] === 8'h6A && got[1] === 8'hA5, "bytes");
    $display("test load done");
  endtask : test_load
  // Bad first byte pulls status low until restart
  task test_bad_sync();
    host.send(8'h55);
    host.send(8'hA5);
    host.falls(2);
    cyc(5);
    check(st_oe === 1'b1 && umode === 1'b0 && ld_oe === 1'b1, "error");
    pulse_request();
    $display("test bad sync done");
  endtask : test_bad_sync
  // Enable gating and user clock source
  task test_user_clk();
    en_n = 1'b1;
    use_usr = 1'b1;
    pulse_request();
    got.delete();
    host.send(SYNC_BYTE_DEFAULT);
    cyc(5);
    check(got.size() == 0 && ld_oe === 1'b1, "loaded while disabled");
    en_n = 1'b0;
    cyc(2);
    host.send(SYNC_BYTE_DEFAULT);
    host.send(8'h3C);
    host.falls(2);
    cyc(5);
    check(umode === 1'b1 && got.size() == 2 && got[1] === 8'h3C, "user clock");
    $display("test user clock done");
  endtask : test_user_clk
  // Watchdog
  initial begin
    #100us;
    err_total++;
    test_done();
  end
  // Main sequence
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    req_n = 1'b1;
    en_n = 1'b0;
    use_usr = 1'b0;
    cyc(10);
    nrst = 1'b1;
    cyc(4);
    test_load();
    pulse_request();
    $display("test restart done");
    test_bad_sync();
    test_user_clk();
    test_done();
  end
endmodule : tb_top
`default_nettype wire

// *** rtl/passive_serial_config_port.sv ***
// Passive serial configuration port: load, chain handoff, error and user mode
`default_nettype none
module passive_serial_config_port
  import ps_config_pkg::*;
#(
  parameter logic [23:0] IMAGE_BITS = ps_config_pkg::IMAGE_BITS_DEFAULT,
  parameter logic [7:0]  SYNC_BYTE  = ps_config_pkg::SYNC_BYTE_DEFAULT
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Configuration pins
  input  wire logic        reconfig_request_n,
  input  wire logic        config_enable_in_n,
  input  wire logic        config_bit_clock,
  input  wire logic        user_supplied_clock,
  input  wire logic        use_user_clock,
  input  wire logic        serial_data_in,
  output logic             config_enable_out_n,
  // Open-drain shared lines
  input  wire logic        config_error_status_n_in,
  output logic             config_error_status_n_out,
  output logic             config_error_status_n_oe,
  input  wire logic        load_complete_in,
  output logic             load_complete_out,
  output logic             load_complete_oe,
  // Loaded data toward the core
  output logic [7:0]       config_byte,
  output logic             config_byte_valid,
  output logic             user_mode
);
  import ps_config_pkg::*;

  logic [6:0] pins_raw;
  logic [6:0] pins_s;
  phase_type  phase;
  phase_type  next_phase;
  logic       clk_prev;
  logic [23:0] bit_count;
  logic [7:0]  shift;
  logic [2:0]  bit_in_byte;
  logic        first_byte_seen;
  logic [1:0]  fall_count;
  logic        error_flag;
  logic        own_pull_d1;
  logic        own_pull_d2;

  // Every pin except use_user_clock passes two flip-flops
  assign pins_raw = {load_complete_in, reconfig_request_n, config_enable_in_n,
                     config_bit_clock, user_supplied_clock, serial_data_in,
                     config_error_status_n_in};

  pin_sync #(.WIDTH(7)) u_sync (
    .sys_clk      (sys_clk),
    .nrst         (nrst),
    .pin_in       (pins_raw),
    .pin_sync_out (pins_s)
  );

  wire load_s    = pins_s[6];
  wire req_n_s   = pins_s[5];
  wire enable_n  = pins_s[4];
  wire data_s    = pins_s[1];
  wire status_s  = pins_s[0];
  // User clock may stand in for the host bit clock
  wire clk_s     = use_user_clock ? pins_s[2] : pins_s[3];
  wire clk_rise  = clk_s & ~clk_prev;
  wire clk_fall  = ~clk_s & clk_prev;
  // Start-up edges only count once the shared load line is released
  wire init_fall = clk_fall && load_s;

  wire in_reset    = !req_n_s;
  wire loading     = (phase == ST_LOAD);
  wire take_bit    = loading && clk_rise;
  wire byte_done   = take_bit && (bit_in_byte == 3'h7);
  wire [7:0] new_byte = {data_s, shift[7:1]}; // LSB first
  wire sync_bad    = byte_done && !first_byte_seen && (new_byte != SYNC_BYTE);
  wire last_bit    = take_bit && (bit_count == IMAGE_BITS - 24'h000001);
  // Another device on the shared line flagged an error; our own pull, seen
  // through the synchroniser, stays masked for two cycles after release
  wire chain_error = !status_s && !own_pull_d1 && !own_pull_d2 &&
                     (phase != ST_RESET);

  // Phase sequencing
  always_comb begin
    next_phase = phase;
    unique case (phase)
      ST_RESET: next_phase = ST_WAIT;
      // Enable active starts loading at once
      ST_WAIT:  if (!enable_n) next_phase = ST_LOAD;
      ST_LOAD: begin
        if (sync_bad || chain_error)
          next_phase = ST_ERROR;
        else if (last_bit)
          next_phase = ST_INIT;
      end
      ST_INIT:  if (init_fall && fall_count == INIT_FALL_EDGES - 2'h1)
                  next_phase = ST_USER;
      ST_USER:  next_phase = ST_USER;
      ST_ERROR: next_phase = ST_ERROR;
      default:  next_phase = ST_RESET;
    endcase
    if (in_reset)
      next_phase = ST_RESET;
  end

  // Phase and edge tracking
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      phase    <= ST_RESET;
      clk_prev <= 1'b0;
    end else begin
      phase    <= next_phase;
      clk_prev <= clk_s;
    end
  end

  // Shift register and bit counter
  always_ff @(posedge sys_clk) begin
    if (!nrst || in_reset || phase == ST_RESET) begin
      bit_count       <= COUNT_RESET;
      shift           <= 8'h00;
      bit_in_byte     <= 3'h0;
      first_byte_seen <= 1'b0;
    end else if (take_bit) begin
      bit_count   <= bit_count + 24'h000001;
      shift       <= new_byte;
      bit_in_byte <= bit_in_byte + 3'h1;
      if (byte_done)
        first_byte_seen <= 1'b1;
    end
  end

  // Byte output toward the core
  always_ff @(posedge sys_clk) begin
    if (!nrst || in_reset) begin
      config_byte       <= 8'h00;
      config_byte_valid <= 1'b0;
    end else begin
      config_byte_valid <= byte_done && !sync_bad;
      if (byte_done)
        config_byte <= new_byte;
    end
  end

  // Falling edges after load-complete
  always_ff @(posedge sys_clk) begin
    if (!nrst || phase != ST_INIT)
      fall_count <= 2'h0;
    else if (init_fall)
      fall_count <= fall_count + 2'h1;
  end

  // Own pull on the status line, delayed to match its synchroniser, so the
  // line still low from our own reset pull is not taken for another's error
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      own_pull_d1 <= 1'b1;
      own_pull_d2 <= 1'b1;
    end else begin
      own_pull_d1 <= config_error_status_n_oe;
      own_pull_d2 <= own_pull_d1;
    end
  end

  // Sticky error until reset request
  always_ff @(posedge sys_clk) begin
    if (!nrst || in_reset)
      error_flag <= 1'b0;
    else if (next_phase == ST_ERROR)
      error_flag <= 1'b1;
  end

  // Pin outputs
  assign config_error_status_n_out = 1'b0;
  assign config_error_status_n_oe  = error_flag || phase == ST_RESET;
  assign load_complete_out = 1'b0;
  // Held low until the whole stream is
  assign load_complete_oe  = (phase == ST_RESET) || (phase == ST_WAIT) ||
                             (phase == ST_LOAD) || (phase == ST_ERROR);
  // Handoff to the next device after loading
  assign config_enable_out_n = !((phase == ST_INIT) || (phase == ST_USER));
  assign user_mode = (phase == ST_USER);

  // Checks
  chk_load_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (phase == ST_LOAD) |-> load_complete_oe)
    else $error("load complete released during loading");
  chk_reset_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    in_reset |=> (phase == ST_RESET))
    else $error("reset request not obeyed");
  chk_reconfig_user: assert property (@(posedge sys_clk) disable iff (!nrst)
    (phase == ST_USER) && in_reset |=> !user_mode)
    else $error("user mode kept after request");
  chk_enable_out: assert property (@(posedge sys_clk) disable iff (!nrst)
    loading && last_bit && !sync_bad && !chain_error && !in_reset |=> !config_enable_out_n)
    else $error("enable out not driven low");
  chk_start_load: assert property (@(posedge sys_clk) disable iff (!nrst)
    (phase == ST_WAIT) && !enable_n && !in_reset |=> (phase == ST_LOAD))
    else $error("load not started");
  chk_error_pull: assert property (@(posedge sys_clk) disable iff (!nrst)
    (phase == ST_ERROR) |-> config_error_status_n_oe)
    else $error("error line not pulled");
  chk_bit_count: assert property (@(posedge sys_clk) disable iff (!nrst)
    take_bit && !in_reset |=> (bit_count == $past(bit_count) + 24'h000001))
    else $error("bit not counted");
  chk_init_edges: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(user_mode) |-> $past(phase) == ST_INIT && $past(fall_count) == 2'h1)
    else $error("user mode before two falling edges");
  cov_handoff: cover property (@(posedge sys_clk) disable iff (!nrst)
    $fell(config_enable_out_n));
  cov_user: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(user_mode));
  cov_error: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(error_flag));
  cov_reconfig: cover property (@(posedge sys_clk) disable iff (!nrst)
    user_mode ##1 !user_mode);
endmodule : passive_serial_config_port
`default_nettype wire

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for a group of pins from outside the clock domain
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Pins and synchronised copies
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stage1       <= '0;
      pin_sync_out <= '0;
    end else begin
      stage1       <= pin_in;
      pin_sync_out <= stage1;
    end
  end
endmodule : pin_sync
`default_nettype wire

// *** rtl/ps_config_pkg.sv ***
// Constants shared by the passive serial configuration port
`default_nettype none
package ps_config_pkg;
  // Size of the configuration image in bits
  localparam int unsigned IMAGE_BITS_WIDTH  = 24;
  localparam logic [23:0] IMAGE_BITS_DEFAULT = 24'h000040;
  // Falling bit-clock edges after load-complete before user mode
  localparam logic [1:0]  INIT_FALL_EDGES   = 2'h2;
  // Sync-word check: first byte of every image
  localparam logic [7:0]  SYNC_BYTE_DEFAULT = 8'h6A;
  // Bit counter reset value
  localparam logic [23:0] COUNT_RESET       = 24'h000000;
  // Configuration phases
  typedef enum logic [2:0] {
    ST_RESET  = 3'b000,
    ST_WAIT   = 3'b001,
    ST_LOAD   = 3'b010,
    ST_INIT   = 3'b011,
    ST_USER   = 3'b100,
    ST_ERROR  = 3'b101
  } phase_type;
endpackage : ps_config_pkg
`default_nettype wire
